/* sei_pkg.sv */
// Purpose: Shared constants for the sensor event interrupt logic
// Assumes: 10 MHz clock, AHB-Lite register access with one byte register per word
// Notes:   Register indices are multiplied by four to form byte addresses
package sei_pkg;

  // ==========================================================================
  // Register indices
  localparam logic [3:0] IDX_P_UP_LO    = 4'h2;
  localparam logic [3:0] IDX_P_UP_HI    = 4'h3;
  localparam logic [3:0] IDX_P_MID_LO   = 4'h4;
  localparam logic [3:0] IDX_P_MID_HI   = 4'h5;
  localparam logic [3:0] IDX_P_LOW_LO   = 4'h6;
  localparam logic [3:0] IDX_P_LOW_HI   = 4'h7;
  localparam logic [3:0] IDX_T_UP       = 4'h8;
  localparam logic [3:0] IDX_T_MID      = 4'h9;
  localparam logic [3:0] IDX_T_LOW      = 4'ha;
  localparam logic [3:0] IDX_INT_EN     = 4'hb;
  localparam logic [3:0] IDX_INT_ROUTE  = 4'hc;
  localparam logic [3:0] IDX_INT_FLAGS  = 4'hd;
  localparam logic [3:0] IDX_EVT_DIR    = 4'he;
  localparam logic [3:0] IDX_COMP_CTRL  = 4'hf;
  localparam int         ADDR_IDX_LSB   = 2;
  localparam int         ADDR_IDX_MSB   = 5;

  // ==========================================================================
  // Field positions
  localparam int BIT_TEMPERATURE_OUTSIDE_FLAG       = 0;
  localparam int BIT_P_WIN       = 1;
  localparam int BIT_TEMPERATURE_CROSSING_FLAG      = 2;
  localparam int BIT_P_TRAV      = 3;
  localparam int BIT_T_RDY       = 4;
  localparam int BIT_P_RDY       = 5;
  localparam int BIT_ALT_SEL     = 6;
  localparam int BIT_IDLE        = 6;
  localparam int BIT_ORDER_ERR   = 7;
  localparam int BIT_COMP_EN     = 7;
  localparam int BIT_TEMPERATURE_OUTSIDE_FLAG_SIDE  = 0;
  localparam int BIT_P_WIN_SIDE  = 1;
  localparam int BIT_T_CROSS_DIR = 2;
  localparam int BIT_P_CROSS_DIR = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_THRESH    = 8'h00;
  localparam logic [7:0] RST_INT_EN    = 8'h00;
  localparam logic [7:0] RST_INT_ROUTE = 8'h00;
  localparam logic [7:0] RST_COMP_CTRL = 8'h80;

  // ==========================================================================
  // Timing
  localparam int         CLK_PERIOD_NS = 100;
  localparam int         ALT_DELAY_NS  = 5000;
  localparam logic [7:0] ALT_DELAY_CYC = 8'((ALT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

/* sei_top.sv */
// Purpose: Threshold event detection, interrupt flags and pin drive for a pressure/temperature sensor
// Assumes: Conversion engine and command decoder run on MCLK and give one-cycle pulses
// Notes:   Registers hold 8 bits in the low byte of each word; upper bits read zero
`timescale 1ns/1ps

// Summary of operation
// RULE1 - Pressure thresholds stored raw, 0.02 mbar steps
// RULE2 - Altitude mode compares thresholds as signed meters
// RULE3 - Three 16-bit thresholds from byte pairs
// RULE4 - Temperature thresholds are signed 8-bit degrees
// RULE5 - Flag inconsistent threshold ordering as error
// RULE6 - Ready flags rise when conversions complete
// RULE7 - Crossing flag when middle threshold crossed
// RULE8 - Outside flag when value leaves window
// RULE9 - Six flags stay high until cleared; the code reloads the four crossing/outside flags on each conversion
// RULE10 - Each interrupt has its own enable
// RULE11 - Crossing/outside need ready enabled and high
// RULE12 - Routing bit drives pin; flag still visible
// RULE13 - Altitude select picks pressure or altitude
// RULE14 - Idle bit only while device sleeps
// RULE15 - Host accesses device only while idle
// RULE16 - Outside side: 1 above, 0 below
// RULE17 - Crossing sense: 1 rising, 0 falling
// RULE18 - Altitude valid 5 us after pressure ready
// RULE19 - Convert and combined reads clear both readies
// RULE20 - Single reads clear only their ready
// RULE21 - Soft reset clears all flags and bits
// RULE22 - Compensation enable selects compensated output
// RULE23 - Pin is OR of enabled, routed flags
module sei_top
  import sei_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        PRS_DONE,
  input  wire logic [15:0] PRS_VALUE,
  input  wire logic        TMP_DONE,
  input  wire logic [7:0]  TMP_VALUE,
  input  wire logic        CMD_CONVERT,
  input  wire logic        CMD_READ_COMBINED,
  input  wire logic        CMD_READ_PRS,
  input  wire logic        CMD_READ_TMP,
  input  wire logic        CMD_SOFT_RST,
  input  wire logic        DEV_SLEEPING,
  output logic             INTERRUPT_PIN_ONE,
  output logic             ALTITUDE_SELECT,
  output logic             COMPENSATION_ENABLE,
  output logic             ALTITUDE_VALID
);
  import sei_pkg::*;

  // ==========================================================================
  // Compare helper
  function automatic logic lt16(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    lt16 = sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

  // ==========================================================================
  // State
  logic [15:0] p_up_r, p_mid_r, p_low_r;
  logic [7:0]  t_up_r, t_mid_r, t_low_r;
  logic [5:0]  int_en_r, int_route_r;
  logic        alt_sel_r, comp_en_r;
  logic        p_rdy_r, t_rdy_r, p_win_r, temperature_outside_flag_r, p_trav_r, temperature_crossing_flag_r;
  logic        p_side_r, t_side_r, p_sense_r, t_sense_r;
  logic        order_err_r, idle_r, interrupt_pin_one_r, alt_valid_r;
  logic [7:0]  alt_cnt_r;
  logic [15:0] prev_p_r, prev_t_r;
  logic        prev_p_ok_r, prev_t_ok_r;
  logic        wr_pend_r;
  logic [3:0]  wr_idx_r;
  logic [31:0] hrdata_r;
  logic        hready_r, hresp_r;

  // ==========================================================================
  // Bus decode
  wire         addr_phase = HSEL & HTRANS[1] & HREADY;
  wire [3:0]   addr_idx   = HADDR[ADDR_IDX_MSB:ADDR_IDX_LSB];
  wire         addr_hit   = (HADDR[31:ADDR_IDX_MSB+1] == '0);
  wire         rd_start   = addr_phase & ~HWRITE;
  wire         wr_start   = addr_phase & HWRITE & addr_hit;
  wire [7:0]   wbyte      = HWDATA[7:0];
  wire         wr_p_up_lo = wr_pend_r & (wr_idx_r == IDX_P_UP_LO);
  wire         wr_p_up_hi = wr_pend_r & (wr_idx_r == IDX_P_UP_HI);
  wire         wr_p_md_lo = wr_pend_r & (wr_idx_r == IDX_P_MID_LO);
  wire         wr_p_md_hi = wr_pend_r & (wr_idx_r == IDX_P_MID_HI);
  wire         wr_p_lw_lo = wr_pend_r & (wr_idx_r == IDX_P_LOW_LO);
  wire         wr_p_lw_hi = wr_pend_r & (wr_idx_r == IDX_P_LOW_HI);
  wire         wr_t_up    = wr_pend_r & (wr_idx_r == IDX_T_UP);
  wire         wr_t_mid   = wr_pend_r & (wr_idx_r == IDX_T_MID);
  wire         wr_t_low   = wr_pend_r & (wr_idx_r == IDX_T_LOW);
  wire         wr_int_en  = wr_pend_r & (wr_idx_r == IDX_INT_EN);
  wire         wr_route   = wr_pend_r & (wr_idx_r == IDX_INT_ROUTE);
  wire         wr_comp    = wr_pend_r & (wr_idx_r == IDX_COMP_CTRL);

  // ==========================================================================
  // Threshold evaluation
  wire [15:0]  t_up_x   = {{8{t_up_r[7]}}, t_up_r};   // RULE4
  wire [15:0]  t_mid_x  = {{8{t_mid_r[7]}}, t_mid_r};
  wire [15:0]  t_low_x  = {{8{t_low_r[7]}}, t_low_r};
  wire [15:0]  t_cur_x  = {{8{TMP_VALUE[7]}}, TMP_VALUE};
  wire         p_sgn    = alt_sel_r;                  // RULE2 RULE13
  wire         p_above  = lt16(p_up_r, PRS_VALUE, p_sgn);   // RULE8
  wire         p_below  = lt16(PRS_VALUE, p_low_r, p_sgn);
  wire         t_above  = lt16(t_up_x, t_cur_x, 1'b1);
  wire         t_below  = lt16(t_cur_x, t_low_x, 1'b1);
  wire         p_prev_lo = lt16(prev_p_r, p_mid_r, p_sgn);
  wire         p_cur_lo  = lt16(PRS_VALUE, p_mid_r, p_sgn);
  wire         t_prev_lo = lt16(prev_t_r, t_mid_x, 1'b1);
  wire         t_cur_lo  = lt16(t_cur_x, t_mid_x, 1'b1);
  wire         p_cross   = prev_p_ok_r & (p_prev_lo ^ p_cur_lo);   // RULE7
  wire         t_cross   = prev_t_ok_r & (t_prev_lo ^ t_cur_lo);
  wire         order_bad = lt16(p_up_r, p_low_r, p_sgn) | lt16(p_mid_r, p_low_r, p_sgn) |
                           lt16(p_up_r, p_mid_r, p_sgn) | lt16(t_up_x, t_low_x, 1'b1) |
                           lt16(t_mid_x, t_low_x, 1'b1) | lt16(t_up_x, t_mid_x, 1'b1);  // RULE5

  // ==========================================================================
  // Flag control
  wire         clr_p    = CMD_CONVERT | CMD_READ_COMBINED | CMD_READ_PRS;   // RULE19 RULE20
  wire         clr_t    = CMD_CONVERT | CMD_READ_COMBINED | CMD_READ_TMP;   // RULE19 RULE20
  wire         set_p    = PRS_DONE & int_en_r[BIT_P_RDY];                   // RULE6 RULE10
  wire         set_t    = TMP_DONE & int_en_r[BIT_T_RDY];
  wire         p_rdy_nxt = CMD_SOFT_RST ? 1'b0 : set_p ? 1'b1 : clr_p ? 1'b0 : p_rdy_r;  // RULE9 RULE21
  wire         t_rdy_nxt = CMD_SOFT_RST ? 1'b0 : set_t ? 1'b1 : clr_t ? 1'b0 : t_rdy_r;
  wire         p_gate   = p_rdy_r & int_en_r[BIT_P_RDY];                     // RULE11
  wire         t_gate   = t_rdy_r & int_en_r[BIT_T_RDY];
  wire [5:0]   src;
  assign src[BIT_TEMPERATURE_OUTSIDE_FLAG]  = temperature_outside_flag_r & t_gate & int_en_r[BIT_TEMPERATURE_OUTSIDE_FLAG];          // RULE10 RULE11
  assign src[BIT_P_WIN]  = p_win_r & p_gate & int_en_r[BIT_P_WIN];
  assign src[BIT_TEMPERATURE_CROSSING_FLAG] = temperature_crossing_flag_r & t_gate & int_en_r[BIT_TEMPERATURE_CROSSING_FLAG];
  assign src[BIT_P_TRAV] = p_trav_r & p_gate & int_en_r[BIT_P_TRAV];
  assign src[BIT_T_RDY]  = t_gate;
  assign src[BIT_P_RDY]  = p_gate;
  wire         interrupt_pin_one_nxt = |(src & int_route_r);                              // RULE12 RULE23

  // ==========================================================================
  // Read mux
  logic [7:0]  rd_byte;
  always_comb begin
    case (addr_idx)
      IDX_P_UP_LO:   rd_byte = p_up_r[7:0];
      IDX_P_UP_HI:   rd_byte = p_up_r[15:8];
      IDX_P_MID_LO:  rd_byte = p_mid_r[7:0];
      IDX_P_MID_HI:  rd_byte = p_mid_r[15:8];
      IDX_P_LOW_LO:  rd_byte = p_low_r[7:0];
      IDX_P_LOW_HI:  rd_byte = p_low_r[15:8];
      IDX_T_UP:      rd_byte = t_up_r;
      IDX_T_MID:     rd_byte = t_mid_r;
      IDX_T_LOW:     rd_byte = t_low_r;
      IDX_INT_EN:    rd_byte = {2'b00, int_en_r};
      IDX_INT_ROUTE: rd_byte = {1'b0, alt_sel_r, int_route_r};
      IDX_INT_FLAGS: rd_byte = {order_err_r, idle_r, src};                   // RULE14
      IDX_EVT_DIR:   rd_byte = {comp_en_r, 3'b000, p_sense_r, t_sense_r, p_side_r, t_side_r};
      IDX_COMP_CTRL: rd_byte = {comp_en_r, 7'h00};
      default:       rd_byte = 8'h00;
    endcase
  end
  wire         rd_fwd   = wr_pend_r & (wr_idx_r == addr_idx) & (addr_idx != IDX_INT_FLAGS) &
                          (addr_idx != IDX_EVT_DIR) & (addr_idx >= IDX_P_UP_LO);
  wire [7:0]   rd_val   = ~addr_hit ? 8'h00 : rd_fwd ? wbyte : rd_byte;

  // ==========================================================================
  // Bus slave
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 4'h0;
      hrdata_r  <= 32'h0000_0000;
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
    end else if (CE) begin
      wr_pend_r <= wr_start;
      wr_idx_r  <= addr_idx;
      if (rd_start) begin
        hrdata_r <= {24'h00_0000, rd_val};
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      p_up_r      <= {RST_THRESH, RST_THRESH};
      p_mid_r     <= {RST_THRESH, RST_THRESH};
      p_low_r     <= {RST_THRESH, RST_THRESH};
      t_up_r      <= RST_THRESH;
      t_mid_r     <= RST_THRESH;
      t_low_r     <= RST_THRESH;
      int_en_r    <= RST_INT_EN[5:0];
      int_route_r <= RST_INT_ROUTE[5:0];
      alt_sel_r   <= RST_INT_ROUTE[BIT_ALT_SEL];
      comp_en_r   <= RST_COMP_CTRL[BIT_COMP_EN];
    end else if (CE) begin
      if (wr_p_up_lo) p_up_r[7:0]   <= wbyte;   // RULE1 RULE3
      if (wr_p_up_hi) p_up_r[15:8]  <= wbyte;   // RULE1 RULE3
      if (wr_p_md_lo) p_mid_r[7:0]  <= wbyte;   // RULE3
      if (wr_p_md_hi) p_mid_r[15:8] <= wbyte;   // RULE3
      if (wr_p_lw_lo) p_low_r[7:0]  <= wbyte;   // RULE3
      if (wr_p_lw_hi) p_low_r[15:8] <= wbyte;   // RULE3
      if (wr_t_up)    t_up_r        <= wbyte;   // RULE4
      if (wr_t_mid)   t_mid_r       <= wbyte;
      if (wr_t_low)   t_low_r       <= wbyte;
      if (wr_int_en)  int_en_r      <= wbyte[5:0];   // RULE10
      if (wr_route) begin
        int_route_r <= wbyte[5:0];   // RULE12
        alt_sel_r   <= wbyte[BIT_ALT_SEL];   // RULE13
      end
      if (wr_comp)    comp_en_r     <= wbyte[BIT_COMP_EN];   // RULE22
    end
  end

  // ==========================================================================
  // Event flags
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      p_rdy_r     <= 1'b0;
      t_rdy_r     <= 1'b0;
      p_win_r     <= 1'b0;
      temperature_outside_flag_r     <= 1'b0;
      p_trav_r    <= 1'b0;
      temperature_crossing_flag_r    <= 1'b0;
      p_side_r    <= 1'b0;
      t_side_r    <= 1'b0;
      p_sense_r   <= 1'b0;
      t_sense_r   <= 1'b0;
      prev_p_r    <= 16'h0000;
      prev_t_r    <= 16'h0000;
      prev_p_ok_r <= 1'b0;
      prev_t_ok_r <= 1'b0;
    end else if (CE) begin
      p_rdy_r <= p_rdy_nxt;   // RULE6 RULE9
      t_rdy_r <= t_rdy_nxt;   // RULE6 RULE9
      if (CMD_SOFT_RST) begin
        p_win_r     <= 1'b0;   // RULE21
        temperature_outside_flag_r     <= 1'b0;
        p_trav_r    <= 1'b0;
        temperature_crossing_flag_r    <= 1'b0;
        p_side_r    <= 1'b0;
        t_side_r    <= 1'b0;
        p_sense_r   <= 1'b0;
        t_sense_r   <= 1'b0;
        prev_p_ok_r <= 1'b0;
        prev_t_ok_r <= 1'b0;
      end else begin
        if (PRS_DONE) begin
          p_win_r     <= p_above | p_below;   // RULE8
          p_trav_r    <= p_cross;             // RULE7
          prev_p_r    <= PRS_VALUE;
          prev_p_ok_r <= 1'b1;
          if (p_above | p_below) p_side_r <= p_above;   // RULE16
          if (p_cross) p_sense_r <= p_prev_lo;          // RULE17
        end
        if (TMP_DONE) begin
          temperature_outside_flag_r     <= t_above | t_below;   // RULE8
          temperature_crossing_flag_r    <= t_cross;             // RULE7
          prev_t_r    <= t_cur_x;
          prev_t_ok_r <= 1'b1;
          if (t_above | t_below) t_side_r <= t_above;   // RULE16
          if (t_cross) t_sense_r <= t_prev_lo;          // RULE17
        end
      end
    end
  end

  // ==========================================================================
  // Status, pin and altitude delay
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      order_err_r <= 1'b0;
      idle_r      <= 1'b0;
      interrupt_pin_one_r      <= 1'b0;
      alt_cnt_r   <= 8'h00;
      alt_valid_r <= 1'b0;
    end else if (CE) begin
      order_err_r <= order_bad;      // RULE5
      idle_r      <= DEV_SLEEPING;   // RULE14
      interrupt_pin_one_r      <= interrupt_pin_one_nxt;       // RULE23
      if (CMD_SOFT_RST) begin
        alt_cnt_r   <= 8'h00;
        alt_valid_r <= 1'b0;
      end else if (PRS_DONE) begin
        alt_cnt_r   <= ALT_DELAY_CYC;   // RULE18
        alt_valid_r <= 1'b0;
      end else if (alt_cnt_r != 8'h00) begin
        alt_cnt_r   <= alt_cnt_r - 8'h01;
        alt_valid_r <= (alt_cnt_r == 8'h01);   // RULE18
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign HRDATA              = hrdata_r;
  assign HREADYOUT           = hready_r;
  assign HRESP               = hresp_r;
  assign INTERRUPT_PIN_ONE   = interrupt_pin_one_r;
  assign ALTITUDE_SELECT     = alt_sel_r;
  assign COMPENSATION_ENABLE = comp_en_r;   // RULE22
  assign ALTITUDE_VALID      = alt_valid_r;

endmodule

/* sei_top_props.sv */
// Purpose: Port checks for sei_top
// Assumes: CE held high by the bench
// Notes:   Attached by the bind at the foot
`timescale 1ns/1ps
module sei_top_props (
  input wire logic        MCLK,
  input wire logic        RST_B,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        PRS_DONE,
  input wire logic        TMP_DONE,
  input wire logic        CMD_CONVERT,
  input wire logic        CMD_READ_COMBINED,
  input wire logic        CMD_READ_PRS,
  input wire logic        CMD_READ_TMP,
  input wire logic        CMD_SOFT_RST,
  input wire logic        INTERRUPT_PIN_ONE,
  input wire logic        ALTITUDE_SELECT,
  input wire logic        COMPENSATION_ENABLE,
  input wire logic        ALTITUDE_VALID
);
  // ==========================================
  // Helpers
  wire wr_take  = HSEL & HTRANS[1] & HWRITE;
  wire wr_route = wr_take & (HADDR == 32'h30);
  wire wr_comp  = wr_take & (HADDR == 32'h3c);
  wire done_any = PRS_DONE | TMP_DONE;
  wire clr_both = CMD_CONVERT | CMD_READ_COMBINED;
  wire clr_any  = clr_both | CMD_READ_PRS | CMD_READ_TMP | CMD_SOFT_RST;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // ==========================================
  // Assertions
  AST_ALT_LATE: assert property ($rose(ALTITUDE_VALID) |-> $past(PRS_DONE, 50) || $past(PRS_DONE, 51))
    else $error("altitude valid rose off time");
  AST_ALT_DROP: assert property (PRS_DONE |=> !ALTITUDE_VALID [*8])
    else $error("altitude valid high too soon");
  AST_SOFT_CLEAR: assert property (CMD_SOFT_RST |-> ##2 !INTERRUPT_PIN_ONE)
    else $error("pin high after soft reset");
  AST_BOTH_CLEAR: assert property (clr_both && !done_any |-> ##2 !INTERRUPT_PIN_ONE)
    else $error("pin high after clearing both readies");
  AST_PIN_CAUSE: assert property ($rose(INTERRUPT_PIN_ONE) |-> $past(done_any, 2) || $past(wr_take, 3))
    else $error("pin rose without cause");
  AST_PIN_HOLD: assert property ($fell(INTERRUPT_PIN_ONE) |-> $past(clr_any, 2) || $past(done_any, 2)
                                 || $past(wr_take, 3))
    else $error("pin fell without cause");
  AST_ALT_SEL: assert property ($changed(ALTITUDE_SELECT) |-> $past(wr_route, 2))
    else $error("altitude select changed without write");
  AST_COMP: assert property ($changed(COMPENSATION_ENABLE) |-> $past(wr_comp, 2))
    else $error("compensation enable changed without write");
  cover property ($rose(INTERRUPT_PIN_ONE));
  cover property ($rose(ALTITUDE_VALID));
  cover property (CMD_SOFT_RST ##2 !INTERRUPT_PIN_ONE);
endmodule

bind sei_top sei_top_props u_props (
  .MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .PRS_DONE(PRS_DONE), .TMP_DONE(TMP_DONE), .CMD_CONVERT(CMD_CONVERT), .CMD_READ_COMBINED(CMD_READ_COMBINED),
  .CMD_READ_PRS(CMD_READ_PRS), .CMD_READ_TMP(CMD_READ_TMP), .CMD_SOFT_RST(CMD_SOFT_RST),
  .INTERRUPT_PIN_ONE(INTERRUPT_PIN_ONE), .ALTITUDE_SELECT(ALTITUDE_SELECT),
  .COMPENSATION_ENABLE(COMPENSATION_ENABLE), .ALTITUDE_VALID(ALTITUDE_VALID)
);

/* sei_engine_model.sv */
// Purpose: Conversion engine and command source beside sei_top
// Assumes: Results and commands are one-cycle pulses on MCLK
// Notes:   Result buses carry inverted data outside their pulse
`timescale 1ns/1ps
module sei_engine_model (
  input  wire logic        mclk,
  output logic             prs_done = 1'b0,
  output logic [15:0]      prs_value = 16'hffff,
  output logic             tmp_done = 1'b0,
  output logic [7:0]       tmp_value = 8'hff,
  output logic [4:0]       cmd = 5'h00,
  output logic             sleeping = 1'b1
);
  // ==========================================
  // Conversion with a latency of lat cycles
  task automatic convert(input logic [15:0] p, input logic [7:0] t, input int lat);
    @(posedge mclk);
    cmd[0] <= 1'b1;
    sleeping <= 1'b0;
    @(posedge mclk);
    cmd[0] <= 1'b0;
    repeat (lat) @(posedge mclk);
    tmp_done <= 1'b1;
    tmp_value <= t;
    @(posedge mclk);
    tmp_done <= 1'b0;
    tmp_value <= ~t;
    prs_done <= 1'b1;
    prs_value <= p;
    @(posedge mclk);
    prs_done <= 1'b0;
    prs_value <= ~p;
    sleeping <= 1'b1;
  endtask

  task automatic command(input int idx);
    @(posedge mclk);
    cmd[idx] <= 1'b1;
    @(posedge mclk);
    cmd[idx] <= 1'b0;
  endtask
endmodule

/* tb.sv */
// Purpose: Self-checking bench for sei_top
// Assumes: Bus accesses only while the engine sleeps
// Notes:   Pressure thresholds switch to altitude mode early on
`timescale 1ns/1ps
module tb;
  logic        mclk;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        prs_done;
  logic [15:0] prs_value;
  logic        tmp_done;
  logic [7:0]  tmp_value;
  logic [4:0]  cmd;
  logic        sleeping;
  logic        pin;
  logic        alt_sel;
  logic        comp_en;
  logic        alt_valid;
  int          errors = 0;
  int          n_compared = 0;

  sei_top u_dut (
    .MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PRS_DONE(prs_done), .PRS_VALUE(prs_value),
    .TMP_DONE(tmp_done), .TMP_VALUE(tmp_value), .CMD_CONVERT(cmd[0]), .CMD_READ_COMBINED(cmd[1]),
    .CMD_READ_PRS(cmd[2]), .CMD_READ_TMP(cmd[3]), .CMD_SOFT_RST(cmd[4]), .DEV_SLEEPING(sleeping),
    .INTERRUPT_PIN_ONE(pin), .ALTITUDE_SELECT(alt_sel), .COMPENSATION_ENABLE(comp_en),
    .ALTITUDE_VALID(alt_valid)
  );
  sei_engine_model eng (
    .mclk(mclk), .prs_done(prs_done), .prs_value(prs_value), .tmp_done(tmp_done),
    .tmp_value(tmp_value), .cmd(cmd), .sleeping(sleeping)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ==========================================
  // Compare, bus and report tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_pin(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic wr16(input logic [31:0] a, input logic [15:0] v);
    wr(a, {24'h0, v[7:0]});
    wr(a + 32'h4, {24'h0, v[15:8]});
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk($sformatf("reg_%h", a[7:0]), exp, q);
  endtask

  function automatic logic [15:0] p_th(input real mbar);
    return 16'(int'(mbar / 0.02));
  endfunction

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic sc_reset_map();
    for (int a = 8; a <= 'h30; a += 4) rd_chk(32'(a), 32'h0);
    rd_chk(32'h34, 32'h40);
    rd_chk(32'h38, 32'h80);
    rd_chk(32'h3c, 32'h80);
    rd_chk(32'h00, 32'h0);
    rd_chk(32'h40, 32'h0);
    wr(32'h34, 32'hff);
    rd_chk(32'h34, 32'h40);
    chk_pin("hresp", 1'b0, hresp);
    chk_pin("hreadyout", 1'b1, hreadyout);
  endtask

  task automatic sc_thresholds();
    wr(32'h20, 32'h2d);
    wr(32'h28, 32'hec);
    wr16(32'h08, p_th(900.0));
    wr16(32'h10, p_th(850.0));
    wr16(32'h18, p_th(800.06));
    rd_chk(32'h34, 32'h40);
    rd_chk(32'h08, 32'hc8);
    rd_chk(32'h0c, 32'haf);
    wr16(32'h08, 16'h1388);
    wr16(32'h10, 16'h0000);
    wr16(32'h18, 16'hfc18);
    rd_chk(32'h34, 32'hc0);
    wr(32'h30, 32'h40);
    rd_chk(32'h34, 32'h40);
    chk_pin("altitude_select", 1'b1, alt_sel);
  endtask

  task automatic sc_events();
    wr(32'h2c, 32'h3f);
    eng.convert(16'h0100, 8'h05, 20);
    rd_chk(32'h34, 32'h70);
    chk_pin("pin_unrouted", 1'b0, pin);
    wr(32'h30, 32'h7f);
    rd_chk(32'h34, 32'h70);
    chk_pin("pin_routed", 1'b1, pin);
    eng.convert(16'hf000, 8'h32, 1);
    rd_chk(32'h34, 32'h7b);
    rd_chk(32'h38, 32'h81);
    eng.command(3);
    rd_chk(32'h34, 32'h6a);
    rd_chk(32'h38, 32'h81);
    wr(32'h2c, 32'h2f);
    eng.convert(16'h0010, 8'he2, 1);
    rd_chk(32'h34, 32'h68);
    rd_chk(32'h38, 32'h88);
    chk_pin("pin_ready", 1'b1, pin);
    eng.command(4);
    rd_chk(32'h34, 32'h40);
    rd_chk(32'h38, 32'h80);
    chk_pin("pin_soft_reset", 1'b0, pin);
  endtask

  task automatic sc_comp();
    wr(32'h3c, 32'h00);
    rd_chk(32'h38, 32'h00);
    chk_pin("comp_off", 1'b0, comp_en);
    wr(32'h3c, 32'h80);
    rd_chk(32'h3c, 32'h80);
    chk_pin("comp_on", 1'b1, comp_en);
  endtask

  task automatic sc_clear();
    logic [7:0] keep [4] = '{8'h00, 8'h00, 8'h10, 8'h20};
    wr(32'h2c, 32'h3f);
    for (int i = 0; i < 4; i++) begin
      eng.convert(16'h0100, 8'h05, 1);
      eng.command(i);
      rd_chk(32'h34, {24'h0, 8'h40 | keep[i]});
    end
  endtask

  task automatic sc_alt();
    eng.convert(16'h0200, 8'h05, 1);
    @(posedge mclk);
    chk_pin("alt_valid_early", 1'b0, alt_valid);
    repeat (55) @(posedge mclk);
    chk_pin("alt_valid_late", 1'b1, alt_valid);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    sc_reset_map();
    sc_thresholds();
    sc_events();
    sc_comp();
    sc_clear();
    sc_alt();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report();
  end
endmodule
